// ==== lrst_pkg.sv ====
// lrst_pkg: register map, field layout, codes and reset values of the trigger block
// assumes a 32-bit AXI4-Lite master and threshold comparator outputs arriving as pins
// Notes on behaviour
// [RL1] each pattern input is high, low or ignored
// [RL2] pattern spans analog inputs plus sixteen logic inputs
// [RL3] one write sets every pattern position alike
// [RL4] matches combine by AND or by OR
// [RL5] duration switch picks edge or time qualification
// [RL6] without duration, fire on goes true/false
// [RL7] with duration, fire on is true/false timing
// [RL8] timeout fires once condition lasts reference time
// [RL9] longer/shorter fires at end versus reference
// [RL10] equal fires when length within reference +- variation
// [RL11] unequal fires when length outside reference +- variation
// [RL12] inside fires when length between both limits
// [RL13] outside range; limits tied to reference/variation
// [RL14] runt crosses first threshold twice, not second
// [RL15] runt first slope rising, falling or either
// [RL16] negative runt: upper crossed twice, lower never
// [RL17] positive runt: lower crossed twice, upper never
// [RL18] rise time compared longer, shorter, inside, outside; inside and outside use the equal and unequal checks here
// [RL19] rise time edge rising, falling or both
// [RL20] timing starts at first threshold, stops at other
// [RL21] four rise time comparisons offered
// [RL22] inputs synchronised, times counted in clock cycles
// [RL23] single-cycle trigger; reset clears counters and runt state
package lrst_pkg;
  localparam int AW = 6;   // byte address width of the register window
  localparam int TW = 32;  // width of times and counters
  // register byte offsets
  localparam logic [AW-1:0] OFS_CTRL = 6'h00;  // mode and option fields
  localparam logic [AW-1:0] OFS_LVL  = 6'h04;  // required level per input
  localparam logic [AW-1:0] OFS_CARE = 6'h08;  // input is compared when set
  localparam logic [AW-1:0] OFS_SALL = 6'h0C;  // load all positions, reads zero
  localparam logic [AW-1:0] OFS_REF  = 6'h10;  // reference time in cycles
  localparam logic [AW-1:0] OFS_VAR  = 6'h14;  // variation in cycles
  localparam logic [AW-1:0] OFS_LO   = 6'h18;  // lower limit in cycles
  localparam logic [AW-1:0] OFS_HI   = 6'h1C;  // upper limit in cycles
  localparam logic [AW-1:0] OFS_STAT = 6'h20;  // live state, read only
  localparam logic [AW-1:0] OFS_TCNT = 6'h24;  // trigger count, read only
  // control field positions
  localparam int CB_MODE = 0;   // 2 bits
  localparam int CB_OR   = 2;   // 1 selects OR
  localparam int CB_DUR  = 3;   // duration switch
  localparam int CB_TRUE = 4;   // 1 true, 0 false
  localparam int CB_QUAL = 5;   // 3 bits
  localparam int CB_RPOL = 8;   // 2 bits, runt polarity
  localparam int CB_RSLP = 10;  // 2 bits, rise time slope
  localparam int CB_RCMP = 12;  // 2 bits, rise time comparison
  // reset values and counter ceiling
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [TW-1:0] LO_RST = 32'h0000_0000;
  localparam logic [TW-1:0] HI_RST = 32'h0000_0000;
  localparam logic [TW-1:0] CNT_MAX = 32'hFFFF_FFFF;
  // modes
  localparam logic [1:0] MD_PAT  = 2'h0;
  localparam logic [1:0] MD_RUNT = 2'h1;
  localparam logic [1:0] MD_RISE = 2'h2;
  // time qualifications; rise comparison code plus one maps onto GT..NE
  localparam logic [2:0] Q_TMO = 3'h0;
  localparam logic [2:0] Q_GT  = 3'h1;
  localparam logic [2:0] Q_LT  = 3'h2;
  localparam logic [2:0] Q_EQ  = 3'h3;
  localparam logic [2:0] Q_NE  = 3'h4;
  localparam logic [2:0] Q_IN  = 3'h5;
  localparam logic [2:0] Q_OUT = 3'h6;
  // slope and polarity codes
  localparam logic [1:0] PL_POS = 2'h0;
  localparam logic [1:0] PL_NEG = 2'h1;
  // set-all codes
  localparam logic [1:0] SA_HIGH = 2'h1;
  localparam logic [1:0] SA_DC   = 2'h2;
  // bus responses
  localparam logic [1:0] RESP_OK  = 2'h0;
  localparam logic [1:0] RESP_ERR = 2'h2;
  // rise time measurement states, gray along idle-up only; idle-down flips both bits
  typedef enum logic [1:0] {RS_IDLE = 2'h0, RS_UP = 2'h1, RS_DN = 2'h3} lrst_rise_t;
endpackage

// ==== lrst_top.sv ====
// lrst_top: pattern, runt and rise time trigger qualification with register access
// assumes an AXI4-Lite master on aclk and asynchronous comparator outputs on the pins
//
// Design decisions made here: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/100ps
module lrst_top #(
  parameter int NA        = 4,    // analog inputs, two or four
  parameter bit LOGIC_FIT = 1'b1  // sixteen logic inputs fitted
) (
  // clock and reset
  input  wire logic                    aclk,
  input  wire logic                    aresetn,
  // write address and data
  input  wire logic [lrst_pkg::AW-1:0] awaddr,
  input  wire logic                    awvalid,
  output wire logic                    awready,
  input  wire logic [31:0]             wdata,
  input  wire logic [3:0]              wstrb,
  input  wire logic                    wvalid,
  output wire logic                    wready,
  // write response
  output wire logic [1:0]              bresp,
  output wire logic                    bvalid,
  input  wire logic                    bready,
  // read address and data
  input  wire logic [lrst_pkg::AW-1:0] araddr,
  input  wire logic                    arvalid,
  output wire logic                    arready,
  output wire logic [31:0]             rdata,
  output wire logic [1:0]              rresp,
  output wire logic                    rvalid,
  input  wire logic                    rready,
  // comparator outputs from the signals under test
  input  wire logic [NA-1:0]           ana_in,
  input  wire logic [15:0]             logic_in,
  input  wire logic                    lvl_upper_in,
  input  wire logic                    lvl_lower_in,
  // trigger events
  output wire logic                    trig_pulse,
  output wire logic                    runt_pos,
  output wire logic                    runt_neg
);
  import lrst_pkg::*;

  localparam int PW = NA + 16;  // pattern width
  // positions that exist in this variant
  localparam logic [PW-1:0] FIT_M = LOGIC_FIT ? {PW{1'b1}} : {{16{1'b0}}, {NA{1'b1}}};

  // configuration registers and trigger count
  logic [31:0]   ctrl_q;       // control fields
  logic [PW-1:0] lvl_q;        // required level
  logic [PW-1:0] care_q;       // compared positions
  logic [TW-1:0] lo_q;         // lower limit
  logic [TW-1:0] hi_q;         // upper limit
  logic [TW-1:0] tcnt_q;       // triggers seen
  // bus registers
  logic          awready_q;
  logic          wready_q;
  logic          bvalid_q;
  logic [1:0]    bresp_q;
  logic          arready_q;
  logic          rvalid_q;
  logic [1:0]    rresp_q;
  logic [31:0]   rdata_q;
  // synchronisers and pattern state
  logic [PW+1:0] sy1_q;        // first stage, read only by sy2_q
  logic [PW+1:0] sy2_q;        // synchronised inputs
  logic          cond_q;       // combined condition
  logic          cond_p_q;     // condition one cycle earlier
  logic [TW-1:0] cnt_q;        // cycles the wanted state has lasted
  // runt and rise time state
  logic          u_p_q;        // upper level one cycle earlier
  logic          l_p_q;        // lower level one cycle earlier
  logic          pos_arm_q;    // lower crossed upward, upper not yet
  logic          neg_arm_q;    // upper crossed downward, lower not yet
  lrst_rise_t    rs_q;         // rise time measurement
  logic [TW-1:0] rcnt_q;       // transition length so far
  // event outputs
  logic          trig_q;
  logic          rpos_q;
  logic          rneg_q;

  // control fields
  logic [1:0]    mode;
  logic          f_or;
  logic          dur;
  logic          tf;
  logic [2:0]    qual;
  logic [1:0]    rpol;
  logic [1:0]    rslp;
  logic [1:0]    rcmp;
  assign mode = ctrl_q[CB_MODE +: 2];
  assign f_or = ctrl_q[CB_OR];
  assign dur  = ctrl_q[CB_DUR];
  assign tf   = ctrl_q[CB_TRUE];
  assign qual = ctrl_q[CB_QUAL +: 3];
  assign rpol = ctrl_q[CB_RPOL +: 2];
  assign rslp = ctrl_q[CB_RSLP +: 2];
  assign rcmp = ctrl_q[CB_RCMP +: 2];

  // reference and variation follow from the two limits
  logic [TW:0]   sum_w;
  logic [TW-1:0] ref_w;
  logic [TW-1:0] var_w;
  assign sum_w = {1'b0, lo_q} + {1'b0, hi_q};
  assign ref_w = sum_w[TW:1];
  assign var_w = (hi_q - lo_q) >> 1;

  // synchronised levels
  logic [PW-1:0] pin_s;
  logic          lo_s;
  logic          up_s;
  assign pin_s = sy2_q[PW-1:0];
  assign lo_s  = sy2_q[PW];
  assign up_s  = sy2_q[PW+1];

  // byte-lane merge for partial writes
  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
                                        input logic [3:0] s);
    logic [31:0] r;
    r = o;
    for (int i = 0; i < 4; i++) begin
      if (s[i]) r[8*i +: 8] = n[8*i +: 8];
    end
    return r;
  endfunction

  // register read view: hit flag and data
  function automatic logic [32:0] reg_rd(input logic [AW-1:0] a);
    case (a)
      OFS_CTRL: reg_rd = {1'b1, ctrl_q};
      OFS_LVL:  reg_rd = {1'b1, 32'(lvl_q)};
      OFS_CARE: reg_rd = {1'b1, 32'(care_q)};
      OFS_SALL: reg_rd = {1'b1, 32'h0000_0000};
      OFS_REF:  reg_rd = {1'b1, ref_w};
      OFS_VAR:  reg_rd = {1'b1, var_w};
      OFS_LO:   reg_rd = {1'b1, lo_q};
      OFS_HI:   reg_rd = {1'b1, hi_q};
      OFS_STAT: reg_rd = {1'b1, 32'({rs_q, neg_arm_q, pos_arm_q, cond_q})};
      OFS_TCNT: reg_rd = {1'b1, tcnt_q};
      default:  reg_rd = {1'b0, 32'h0000_0000};
    endcase
  endfunction

  // duration judgement shared by pattern and rise time
  function automatic logic judge(input logic [TW-1:0] n, input logic [2:0] q);
    case (q)
      Q_GT:        judge = n > ref_w;                 // [RL9] [RL21]
      Q_LT:        judge = n < ref_w;                 // [RL9] [RL21]
      Q_EQ:        judge = (n >= lo_q) && (n <= hi_q); // [RL10] [RL21]
      Q_NE, Q_OUT: judge = (n < lo_q) || (n > hi_q);   // [RL11] [RL13] [RL21]
      Q_IN:        judge = (n > lo_q) && (n < hi_q);   // [RL12]
      default:     judge = 1'b0;
    endcase
  endfunction

  // bus decode
  logic          we;
  logic [32:0]   rd_w;
  logic [32:0]   wr_w;
  logic [31:0]   wv;
  assign we = awready_q & awvalid & wvalid;
  always_comb begin
    rd_w = reg_rd(araddr);
    wr_w = reg_rd(awaddr);
    wv   = merge(wr_w[31:0], wdata, wstrb);
  end

  // write channel: ready pulses once both halves wait, response follows
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_q <= 1'b0;
      wready_q  <= 1'b0;
      bvalid_q  <= 1'b0;
      bresp_q   <= RESP_OK;
    end else begin
      awready_q <= awvalid & wvalid & ~awready_q & ~bvalid_q;
      wready_q  <= awvalid & wvalid & ~awready_q & ~bvalid_q;
      if (we) begin
        bvalid_q <= 1'b1;
        bresp_q  <= wr_w[32] ? RESP_OK : RESP_ERR;  // unmapped answers error
      end else if (bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  // read channel: data registered on the same edge the address is taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_q <= 1'b0;
      rvalid_q  <= 1'b0;
      rresp_q   <= RESP_OK;
      rdata_q   <= 32'h0000_0000;
    end else begin
      arready_q <= arvalid & ~arready_q & ~rvalid_q;
      if (arready_q & arvalid) begin
        rvalid_q <= 1'b1;
        rdata_q  <= rd_w[31:0];
        rresp_q  <= rd_w[32] ? RESP_OK : RESP_ERR;
      end else if (rready) begin
        rvalid_q <= 1'b0;
      end
    end
  end

  // configuration writes
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q <= CTRL_RST;
      lvl_q  <= '0;
      care_q <= '0;
      lo_q   <= LO_RST;
      hi_q   <= HI_RST;
    end else if (we) begin
      case (awaddr)
        OFS_CTRL: ctrl_q <= wv;
        OFS_LVL:  lvl_q  <= wv[PW-1:0];
        OFS_CARE: care_q <= wv[PW-1:0] & FIT_M;  // [RL2]
        OFS_SALL: begin  // [RL3]
          lvl_q  <= {PW{wv[1:0] == SA_HIGH}};
          care_q <= (wv[1:0] >= SA_DC) ? '0 : FIT_M;
        end
        OFS_REF: begin  // limits move with reference [RL13]
          lo_q <= wv - var_w;
          hi_q <= wv + var_w;
        end
        OFS_VAR: begin  // limits move with variation [RL13]
          lo_q <= ref_w - wv;
          hi_q <= ref_w + wv;
        end
        OFS_LO:   lo_q <= wv;
        OFS_HI:   hi_q <= wv;
        default:  ;
      endcase
    end
  end

  // two-stage synchroniser for every comparator output [RL22]
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sy1_q <= '0;
      sy2_q <= '0;
    end else begin
      sy1_q <= {lvl_upper_in, lvl_lower_in, logic_in, ana_in};
      sy2_q <= sy1_q;
    end
  end

  // per-input match; ignored positions drop out [RL1]
  logic [PW-1:0] care_e;
  logic [PW-1:0] match;
  logic          cond;
  assign care_e = care_q & FIT_M;
  assign match  = care_e & ~(pin_s ^ lvl_q);
  assign cond   = f_or ? |match : &(match | ~care_e);  // [RL4]

  // wanted state: condition equal to the true/false choice
  logic          hit_now;
  logic          hit_prev;
  logic [TW-1:0] cnt_nx;
  assign hit_now  = cond_q == tf;
  assign hit_prev = cond_p_q == tf;
  assign cnt_nx   = (cnt_q == CNT_MAX) ? cnt_q : cnt_q + 32'h0000_0001;

  // condition history and duration counter in cycles [RL7] [RL22] [RL23]
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cond_q   <= 1'b0;
      cond_p_q <= 1'b0;
      cnt_q    <= '0;
    end else begin
      cond_q   <= cond;
      cond_p_q <= cond_q;
      cnt_q    <= hit_now ? cnt_nx : '0;
    end
  end

  // pattern decision
  logic p_fire;
  always_comb begin
    p_fire = 1'b0;
    if (!dur) begin  // duration off: edge of the condition [RL5] [RL6]
      p_fire = hit_now && !hit_prev;
    end else if (qual == Q_TMO) begin  // once per episode [RL8]
      p_fire = hit_now && (cnt_nx == ref_w) && (cnt_nx != cnt_q);
    end else begin  // judged when the wanted state ends [RL5] [RL7]
      p_fire = hit_prev && !hit_now && judge(cnt_q, qual);
    end
  end

  // threshold crossings
  logic u_rise;
  logic u_fall;
  logic l_rise;
  logic l_fall;
  assign u_rise = up_s & ~u_p_q;
  assign u_fall = ~up_s & u_p_q;
  assign l_rise = lo_s & ~l_p_q;
  assign l_fall = ~lo_s & l_p_q;

  // runt arming; a crossing of the other threshold disarms [RL14] [RL23]
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      u_p_q     <= 1'b0;
      l_p_q     <= 1'b0;
      pos_arm_q <= 1'b0;
      neg_arm_q <= 1'b0;
    end else begin
      u_p_q <= up_s;
      l_p_q <= lo_s;
      if (u_rise | l_fall) begin
        pos_arm_q <= 1'b0;
      end else if (l_rise) begin
        pos_arm_q <= 1'b1;
      end
      if (l_fall | u_rise) begin
        neg_arm_q <= 1'b0;
      end else if (u_fall) begin
        neg_arm_q <= 1'b1;
      end
    end
  end

  // runt events filtered by polarity [RL15]
  logic rp_ev;
  logic rn_ev;
  assign rp_ev = pos_arm_q & l_fall & (rpol != PL_NEG);  // [RL17]
  assign rn_ev = neg_arm_q & u_rise & (rpol != PL_POS);  // [RL16]

  // transition timing between the thresholds [RL19] [RL20]
  logic [TW-1:0] rcnt_nx;
  assign rcnt_nx = (rcnt_q == CNT_MAX) ? rcnt_q : rcnt_q + 32'h0000_0001;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rs_q   <= RS_IDLE;
      rcnt_q <= '0;
    end else begin
      case (rs_q)
        RS_IDLE: begin  // start at the first threshold of the slope
          if (l_rise && rslp != PL_NEG) begin
            rs_q   <= RS_UP;
            rcnt_q <= 32'h0000_0001;
          end else if (u_fall && rslp != PL_POS) begin
            rs_q   <= RS_DN;
            rcnt_q <= 32'h0000_0001;
          end
        end
        RS_UP: begin  // stop at upper, abandon if back below lower
          if (up_s || !lo_s) rs_q <= RS_IDLE;
          else rcnt_q <= rcnt_nx;
        end
        RS_DN: begin  // stop at lower, abandon if back above upper
          if (!lo_s || up_s) rs_q <= RS_IDLE;
          else rcnt_q <= rcnt_nx;
        end
        default: rs_q <= RS_IDLE;
      endcase
    end
  end

  // rise time decision when the second threshold is reached [RL18]
  // kept as a process so that limit changes read inside judge re-evaluate it
  logic r_fire;
  always_comb begin
    r_fire = ((rs_q == RS_UP && up_s) || (rs_q == RS_DN && !lo_s))
             && judge(rcnt_q, 3'(rcmp) + 3'h1);
  end

  // active mode selects the event
  logic t_ev;
  always_comb begin
    case (mode)
      MD_PAT:  t_ev = p_fire;
      MD_RUNT: t_ev = rp_ev | rn_ev;
      MD_RISE: t_ev = r_fire;
      default: t_ev = 1'b0;
    endcase
  end

  // registered single-cycle events and trigger count [RL23]
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      trig_q <= 1'b0;
      rpos_q <= 1'b0;
      rneg_q <= 1'b0;
      tcnt_q <= '0;
    end else begin
      trig_q <= t_ev;
      rpos_q <= (mode == MD_RUNT) & rp_ev;
      rneg_q <= (mode == MD_RUNT) & rn_ev;
      if (t_ev) tcnt_q <= tcnt_q + 32'h0000_0001;
    end
  end

  // outputs straight from flip-flops
  assign awready    = awready_q;
  assign wready     = wready_q;
  assign bvalid     = bvalid_q;
  assign bresp      = bresp_q;
  assign arready    = arready_q;
  assign rvalid     = rvalid_q;
  assign rresp      = rresp_q;
  assign rdata      = rdata_q;
  assign trig_pulse = trig_q;
  assign runt_pos   = rpos_q;
  assign runt_neg   = rneg_q;

  // checks
  AST_IGNORE: assert property (@(posedge aclk) disable iff (!aresetn) // [RL1]
    (!f_or && care_e == '0) |=> cond_q) else $error("ignored inputs changed condition");
  AST_SETALL: assert property (@(posedge aclk) disable iff (!aresetn) // [RL3]
    (we && awaddr == OFS_SALL && wstrb[0] && wdata[1:0] == SA_HIGH)
    |=> (care_q == FIT_M) && (&lvl_q)) else $error("set all not applied");
  AST_EDGE: assert property (@(posedge aclk) disable iff (!aresetn) // [RL6]
    (mode == MD_PAT && !dur && hit_now && !hit_prev) |=> trig_pulse)
    else $error("condition edge did not trigger");
  AST_COUNT: assert property (@(posedge aclk) disable iff (!aresetn) // [RL7]
    (hit_now && cnt_q != CNT_MAX) |=> cnt_q == $past(cnt_q) + 32'h0000_0001)
    else $error("duration counter slipped");
  AST_TIMEOUT: assert property (@(posedge aclk) disable iff (!aresetn) // [RL8]
    (mode == MD_PAT && dur && qual == Q_TMO && hit_now && cnt_q != CNT_MAX
     && cnt_q + 32'h0000_0001 == ref_w) |=> trig_pulse) else $error("timeout missed");
  AST_LONGER: assert property (@(posedge aclk) disable iff (!aresetn) // [RL9]
    (mode == MD_PAT && dur && qual == Q_GT && hit_prev && !hit_now && cnt_q <= ref_w)
    |=> !trig_pulse) else $error("short episode triggered longer-than");
  AST_RUNT_NEG: assert property (@(posedge aclk) disable iff (!aresetn) // [RL16]
    (mode == MD_RUNT && neg_arm_q && u_rise && rpol != PL_POS) |=> runt_neg && trig_pulse)
    else $error("negative runt missed");
  AST_RUNT_POS: assert property (@(posedge aclk) disable iff (!aresetn) // [RL17]
    (mode == MD_RUNT && pos_arm_q && l_fall && rpol != PL_NEG) |=> runt_pos && trig_pulse)
    else $error("positive runt missed");
  AST_RISE_GT: assert property (@(posedge aclk) disable iff (!aresetn) // [RL18]
    (mode == MD_RISE && rs_q == RS_UP && up_s && rcmp == 2'h0 && rcnt_q > ref_w)
    |=> trig_pulse) else $error("slow edge missed");
  AST_RESET: assert property (@(posedge aclk) disable iff (!aresetn) // [RL23]
    $rose(aresetn) |-> (cnt_q == '0) && !pos_arm_q && !neg_arm_q && !trig_pulse)
    else $error("state not cleared by reset");
endmodule

// ==== lrst_sig_model.sv ====
// lrst_sig_model: signals under test as seen through their threshold comparators
// assumes the bench calls its tasks just after a rising edge of clk
`timescale 1ns/100ps
module lrst_sig_model #(
  parameter int NA = 4  // analog inputs
) (
  // sampling clock of the bench
  input  wire logic   clk,
  // comparator outputs
  output logic [NA-1:0] ana,
  output logic [15:0]   lgc,
  output logic          up_lvl,
  output logic          low_lvl
);
  // all sources start below every threshold
  initial begin
    ana = '0;
    lgc = '0;
    up_lvl = 1'b0;
    low_lvl = 1'b0;
  end
  // new channel levels at the next edge
  task automatic put(input logic [NA-1:0] a, input logic [15:0] g);
    @(posedge clk);
    ana <= a;
    lgc <= g;
  endtask
  // source level: 0 below lower, 1 between, 2 above upper; upper never without lower
  task automatic lvl(input int c);
    @(posedge clk);
    low_lvl <= (c >= 1);
    up_lvl  <= (c >= 2);
  endtask
endmodule

// ==== logic_runt_slew_trigger_test.sv ====
// logic_runt_slew_trigger_test: register, pattern, duration, runt and rise time checks
// assumes lrst_top with four analog inputs and the logic inputs fitted
`timescale 1ns/100ps
module logic_runt_slew_trigger_test;
  import lrst_pkg::*;
  logic          aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic          awready, wready, bvalid, arready, rvalid, trig_pulse, runt_pos, runt_neg;
  logic [AW-1:0] awaddr, araddr;
  logic [31:0]   wdata, rdata, d, n0, np, nn;
  logic [31:0]   ntrig, npos, nneg, nlong, fails, cmp_count;
  logic [3:0]    wstrb, ana;
  logic [15:0]   lgc;
  logic [1:0]    bresp, rresp, rsp;
  logic          up_lvl, low_lvl, prev;
  // expected trigger per qualifier, bit k for a condition of 4k+4 cycles
  localparam logic [2:0] DT [7] = '{3'b110, 3'b100, 3'b001, 3'b010, 3'b101, 3'b010, 3'b101};
  // runt walk through the levels
  localparam int RS [8] = '{1, 0, 1, 2, 1, 2, 1, 0};
  lrst_top #(.NA(4), .LOGIC_FIT(1'b1)) u_lrst_top (.aclk(aclk), .aresetn(aresetn),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
    .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready), .ana_in(ana), .logic_in(lgc), .lvl_upper_in(up_lvl),
    .lvl_lower_in(low_lvl), .trig_pulse(trig_pulse), .runt_pos(runt_pos), .runt_neg(runt_neg));
  lrst_sig_model #(.NA(4)) u_lrst_sig_model (.clk(aclk), .ana(ana), .lgc(lgc),
    .up_lvl(up_lvl), .low_lvl(low_lvl));
  // 100 MHz clock
  always #5 aclk = ~aclk;
  // count event pulses and any trigger pulse longer than one cycle
  always @(posedge aclk) begin
    if (trig_pulse === 1'b1) ntrig <= ntrig + 1;
    if (runt_pos === 1'b1) npos <= npos + 1;
    if (runt_neg === 1'b1) nneg <= nneg + 1;
    if (trig_pulse === 1'b1 && prev === 1'b1) nlong <= nlong + 1;
    prev <= trig_pulse;
  end
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      fails++;
      $display("FAIL %s expected %h seen %h", n, e, g);
    end
  endtask
  // one write: both channels offered together, each dropped once taken
  task automatic wr(input logic [AW-1:0] a, input logic [31:0] v);
    logic dn;
    dn = 1'b0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!dn) begin
      @(posedge aclk);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
      if (bvalid === 1'b1) begin
        dn = 1'b1;
        rsp = bresp;
        bready <= 1'b0;
      end
    end
  endtask
  // one read, data and response taken at the rvalid edge
  task automatic rd(input logic [AW-1:0] a, output logic [31:0] v);
    logic dn;
    dn = 1'b0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!dn) begin
      @(posedge aclk);
      if (arready === 1'b1) arvalid <= 1'b0;
      if (rvalid === 1'b1) begin
        dn = 1'b1;
        v = rdata;
        rsp = rresp;
        rready <= 1'b0;
      end
    end
  endtask
  // apply a channel pattern and count the triggers it gives
  task automatic pat(input logic [3:0] a, input logic [15:0] g, input logic [31:0] e);
    n0 = ntrig;
    u_lrst_sig_model.put(a, g);
    repeat (8) @(posedge aclk);
    chk("pattern trig", e, ntrig - n0);
  endtask
  // hold a source level for h cycles
  task automatic lv(input int c, input int h);
    u_lrst_sig_model.lvl(c);
    repeat (h - 1) @(posedge aclk);
  endtask
  // cut a hang short
  initial begin
    repeat (30000) @(posedge aclk);
    fails++;
    end_of_test();
  end
  initial begin
    {aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, prev} = '0;
    {awaddr, araddr, wdata, ntrig, npos, nneg, nlong, fails, cmp_count} = '0;
    wstrb = 4'hF;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    rd(OFS_CTRL, d); chk("ctrl reset", CTRL_RST, d);
    chk("read resp", {30'h0000_0000, RESP_OK}, {30'h0000_0000, rsp});
    rd(6'h28, d); chk("unmapped resp", {30'h0, RESP_ERR}, {30'h0, rsp});
    wr(6'h28, 32'h0000_0000);
    chk("unmapped bresp", {30'h0000_0000, RESP_ERR}, {30'h0000_0000, rsp});
    wr(OFS_SALL, {30'h0, SA_HIGH});
    chk("write resp", {30'h0000_0000, RESP_OK}, {30'h0000_0000, rsp});
    rd(OFS_LVL, d); chk("lvl all high", 32'h000F_FFFF, d & 32'h000F_FFFF);
    rd(OFS_CARE, d); chk("care all", 32'h000F_FFFF, d & 32'h000F_FFFF);
    // only byte lane zero written
    wstrb <= 4'h1;
    wr(OFS_LVL, 32'h0000_0000);
    wstrb <= 4'hF;
    rd(OFS_LVL, d); chk("lvl lane0", 32'h000F_FF00, d & 32'h000F_FFFF);
    wr(OFS_SALL, 32'h0000_0000);
    rd(OFS_LVL, d); chk("lvl all low", 32'h0000_0000, d & 32'h000F_FFFF);
    wr(OFS_SALL, {30'h0, SA_DC});
    rd(OFS_CARE, d); chk("care none", 32'h0, d & 32'h000F_FFFF);
    // bit0 high, bit1 low, last logic line high
    wr(OFS_LVL, 32'h0008_0001);
    wr(OFS_CARE, 32'h0000_0003);
    wr(OFS_CTRL, 32'h0000_0010);
    pat(4'b1101, 16'h0000, 1);
    rd(OFS_STAT, d); chk("cond", 32'h1, d & 32'h1);
    pat(4'b0010, 16'h0000, 0);
    wr(OFS_CTRL, 32'h0000_0014);
    pat(4'b0011, 16'h0000, 1);
    pat(4'b0010, 16'h0000, 0);
    wr(OFS_CTRL, 32'h0000_0004);
    pat(4'b0001, 16'h0000, 0);
    pat(4'b0010, 16'h0000, 1);
    wr(OFS_CARE, 32'h0008_0000);
    wr(OFS_CTRL, 32'h0000_0010);
    pat(4'b0010, 16'h8000, 1);
    pat(4'b0000, 16'h0000, 0);
    // duration qualifiers on ana bit0 high, limits 6 and 10
    wr(OFS_CARE, 32'h0000_0001);
    wr(OFS_REF, 32'h0000_0009);
    wr(OFS_VAR, 32'h0000_0003);
    rd(OFS_HI, d); chk("hi from ref var", 32'h0000_000C, d);
    rd(OFS_LO, d); chk("lo from ref var", 32'h0000_0006, d);
    wr(OFS_LO, 32'h0000_0006);
    wr(OFS_HI, 32'h0000_000A);
    rd(OFS_REF, d); chk("ref from limits", 32'h0000_0008, d);
    rd(OFS_VAR, d); chk("var from limits", 32'h0000_0002, d);
    for (int q = 0; q < 7; q++) begin
      wr(OFS_CTRL, 32'h18 | (q << 5));
      for (int k = 0; k < 3; k++) begin
        n0 = ntrig;
        u_lrst_sig_model.put(4'b0001, 16'h0);
        repeat (4 * k + 3) @(posedge aclk);
        u_lrst_sig_model.put(4'b0000, 16'h0);
        repeat (10) @(posedge aclk);
        chk("dur trig", {31'h0, DT[q][k]}, ntrig - n0);
      end
    end
    // runt walk for each polarity
    for (int p = 0; p < 3; p++) begin
      wr(OFS_CTRL, 32'h1 | (p << 8));
      {n0, np, nn} = {ntrig, npos, nneg};
      foreach (RS[i]) lv(RS[i], 6);
      repeat (6) @(posedge aclk);
      chk("runt pos", 32'(p != 1), npos - np);
      chk("runt neg", 32'(p != 0), nneg - nn);
      chk("runt trig", 32'(p != 1) + 32'(p != 0), ntrig - n0);
    end
    // fast and slow edges both ways for each slope and comparison
    for (int s = 0; s < 3; s++) begin
      for (int c = 0; c < 4; c++) begin
        wr(OFS_CTRL, 32'h2 | (s << 10) | (c << 12));
        n0 = ntrig;
        lv(1, 3); lv(2, 6); lv(1, 14); lv(0, 6);
        lv(1, 14); lv(2, 6); lv(1, 3); lv(0, 6);
        chk("rise trig", (c == 2 ? 0 : c == 3 ? 2 : 1) * (s == 2 ? 2 : 1), ntrig - n0);
      end
    end
    rd(OFS_TCNT, d); chk("trig total", ntrig, d);
    chk("long pulses", 32'h0, nlong);
    end_of_test();
  end
endmodule
